// ===== verilog/atta_pkg.sv
// Constants and types for the timing trigger arm block.
// Assumes a single 250 MHz system clock.
`default_nettype none
package atta_pkg;
	localparam int unsigned CLK_PERIOD_NS  = 4;
	localparam int unsigned FILTER_MAX_NS  = 300;
	localparam int unsigned FILTER_MAX_CYC = FILTER_MAX_NS / CLK_PERIOD_NS;
	localparam int unsigned FILT_W         = 7;
	localparam int unsigned NCH            = 8;
	localparam logic [1:0]  MODE_SYNC      = 2'h0;
	localparam logic [1:0]  MODE_ASYNC_RISE = 2'h1;
	localparam logic [1:0]  MODE_ASYNC_FALL = 2'h2;
	localparam logic [1:0]  MODE_RSVD       = 2'h3;
	localparam logic [FILT_W-1:0] FILT_ZERO = 7'h00;
	localparam logic [FILT_W-1:0] FILT_ONE  = 7'h01;
	typedef enum logic [1:0] {
		ATTA_IDLE  = 2'b00,
		ATTA_ARMED = 2'b01,
		ATTA_FIRED = 2'b11
	} atta_state_t;
endpackage : atta_pkg
`default_nettype wire

// ===== verilog/atta_trigger.sv
// Timing unit arming, edge trigger, filter, glitch flags and main-term stretch.
// Assumes probe channels and state clock arrive asynchronously; all else on clk_sys.
// Overview of operation
// - Arm command only arms; trigger fires later on selected recognizer edge, or in sync mode on a state clock edge while match true.
// - Rising mode: match present at arming must drop then return to fire.
// - Falling mode: fire as soon as match goes true to false after arming.
// - Unconditional first-step arm advances step on first state clock after start.
// - Main false term holds only if recognizer false for whole state cycle.
// - Main term sees stretched level; timing trigger uses edges.
// - Programmable 0 to 300 ns filter suppresses shorter spurious events.
// - Async mode samples channels and glitches on internal timebase, stores both.
// - One clocking mode at a time; changing either selection updates both.
// - Trigger mode offers sync, async rising, async falling.
// - Main acquisition captures nothing without a main trigger command.
// - Nonzero filter: condition must persist filter duration before firing.
// - Glitch flagged when a channel transitions more than once between samples.
// - Pattern bit 7 is channel 7, bit 0 is channel 0.
`default_nettype none
module atta_trigger
	import atta_pkg::*;
(
	// Clock and reset
	input  wire logic              clk_sys,
	input  wire logic              rst,
	// Probe and system under test
	input  wire logic [NCH-1:0]    probe_in,
	input  wire logic              state_clk,
	// Program control
	input  wire logic              acq_start,
	input  wire logic              arm_cmd,
	input  wire logic              uncond_arm_step,
	input  wire logic              main_trig_cmd,
	// Configuration
	input  wire logic [NCH-1:0]    pat_value,
	input  wire logic [NCH-1:0]    pat_care,
	input  wire logic [FILT_W-1:0] filter_cycles,
	input  wire logic [FILT_W-1:0] sample_div,
	input  wire logic [1:0]        trig_mode_wr,
	input  wire logic              trig_mode_we,
	input  wire logic              main_async_wr,
	input  wire logic              main_async_we,
	// Status and data
	output logic                   armed,
	output logic                   timing_trig,
	output logic                   step_advance,
	output logic                   main_term_true,
	output logic                   main_term_false,
	output logic                   main_capture_en,
	output logic [1:0]             trig_mode,
	output logic                   async_mode,
	output logic                   sample_valid,
	output logic [NCH-1:0]         sample_data,
	output logic [NCH-1:0]         sample_glitch,
	output logic                   recog_match
);
	// Synchronisers
	logic [NCH-1:0] pr_s1_q, pr_s2_q, pr_s3_q;
	logic           sc_s1_q, sc_s2_q, sc_s3_q;
	always_ff @(posedge clk_sys) begin
		pr_s1_q <= probe_in;
		pr_s2_q <= pr_s1_q;
		pr_s3_q <= pr_s2_q;
		sc_s1_q <= state_clk;
		sc_s2_q <= sc_s1_q;
		sc_s3_q <= sc_s2_q;
	end
	wire logic sc_rise = sc_s2_q & ~sc_s3_q;

	// Mode link
	logic [1:0] mode_q, mode_d;
	always_comb begin
		mode_d = mode_q;
		if (trig_mode_we && trig_mode_wr != MODE_RSVD) begin
			mode_d = trig_mode_wr;
		end else if (main_async_we) begin
			if (!main_async_wr) begin
				mode_d = MODE_SYNC;
			end else if (mode_q == MODE_SYNC) begin
				mode_d = MODE_ASYNC_RISE;
			end
		end
	end
	wire logic is_async = (mode_q != MODE_SYNC);

	// Recognizer with filter
	function automatic logic pat_match(input logic [NCH-1:0] d, input logic [NCH-1:0] v,
			input logic [NCH-1:0] c);
		pat_match = ((d ^ v) & c) == {NCH{1'b0}};
	endfunction : pat_match
	wire logic raw_match = pat_match(pr_s2_q, pat_value, pat_care);
	logic [FILT_W-1:0] filt_cnt_q, filt_cnt_d;
	logic              filt_q, filt_d, filt_prev_q;
	always_comb begin
		filt_cnt_d = filt_cnt_q;
		filt_d     = filt_q;
		if (raw_match == filt_q) begin
			filt_cnt_d = FILT_ZERO;
		end else if (filt_cnt_q + FILT_ONE >= filter_cycles) begin
			filt_d     = raw_match;
			filt_cnt_d = FILT_ZERO;
		end else begin
			filt_cnt_d = filt_cnt_q + FILT_ONE;
		end
	end
	wire logic rec_rise = filt_q & ~filt_prev_q;
	wire logic rec_fall = ~filt_q & filt_prev_q;

	// Arm and trigger state machine
	atta_state_t st_q, st_d;
	logic        seen_false_q, seen_false_d, trig_d, step_d, step_pend_q, step_pend_d;
	always_comb begin
		st_d         = st_q;
		seen_false_d = seen_false_q;
		trig_d       = 1'b0;
		step_pend_d  = step_pend_q;
		step_d       = 1'b0;
		if (step_pend_q && sc_rise) begin
			step_d      = 1'b1;
			step_pend_d = 1'b0;
		end
		// A new start wins over a consumed one
		if (acq_start && uncond_arm_step) begin
			step_pend_d = 1'b1;
		end
		case (st_q)
			ATTA_IDLE: begin
				if (arm_cmd || (acq_start && uncond_arm_step)) begin
					st_d         = ATTA_ARMED;
					seen_false_d = ~filt_q;
				end
			end
			ATTA_ARMED: begin
				if (!filt_q) begin
					seen_false_d = 1'b1;
				end
				if (mode_q == MODE_ASYNC_RISE && seen_false_q && rec_rise) begin
					st_d   = ATTA_FIRED;
					trig_d = 1'b1;
				end else if (mode_q == MODE_ASYNC_FALL && rec_fall) begin
					st_d   = ATTA_FIRED;
					trig_d = 1'b1;
				end else if (mode_q == MODE_SYNC && sc_rise && filt_q) begin
					st_d   = ATTA_FIRED;
					trig_d = 1'b1;
				end
			end
			ATTA_FIRED: begin
				if (acq_start && uncond_arm_step) begin
					st_d         = ATTA_ARMED;
					seen_false_d = ~filt_q;
				end else if (acq_start) begin
					st_d = ATTA_IDLE;
				end
			end
			default: st_d = ATTA_IDLE;
		endcase
	end

	// Pulse stretch over state clock cycle
	logic seen_true_q, seen_true_d, term_t_q, term_t_d, term_f_q, term_f_d;
	always_comb begin
		seen_true_d = seen_true_q | filt_q;
		term_t_d    = term_t_q;
		term_f_d    = term_f_q;
		if (sc_rise) begin
			term_t_d    = seen_true_q | filt_q;
			term_f_d    = ~(seen_true_q | filt_q);
			seen_true_d = 1'b0;
		end
	end

	// Async sampling and glitch detection
	logic [FILT_W-1:0] div_q, div_d;
	logic [NCH-1:0]    once_q, once_d, gl_q, gl_d, sdat_q, sdat_d, sgl_q, sgl_d;
	logic              sv_q, sv_d;
	always_comb begin
		div_d  = div_q + FILT_ONE;
		once_d = once_q | (pr_s2_q ^ pr_s3_q);
		gl_d   = gl_q | (once_q & (pr_s2_q ^ pr_s3_q));
		sdat_d = sdat_q;
		sgl_d  = sgl_q;
		sv_d   = 1'b0;
		if (is_async && div_q >= sample_div) begin
			div_d  = FILT_ZERO;
			sdat_d = pr_s2_q;
			sgl_d  = gl_d;
			sv_d   = 1'b1;
			once_d = {NCH{1'b0}};
			gl_d   = {NCH{1'b0}};
		end else if (!is_async) begin
			div_d = FILT_ZERO;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (rst) begin
			mode_q <= MODE_SYNC;
			filt_cnt_q <= FILT_ZERO;
			filt_q <= 1'b0;
			filt_prev_q <= 1'b0;
			st_q <= ATTA_IDLE;
			seen_false_q <= 1'b0;
			step_pend_q <= 1'b0;
			timing_trig <= 1'b0;
			step_advance <= 1'b0;
			seen_true_q <= 1'b0;
			term_t_q <= 1'b0;
			term_f_q <= 1'b0;
			div_q <= FILT_ZERO;
			once_q <= {NCH{1'b0}};
			gl_q <= {NCH{1'b0}};
			sdat_q <= {NCH{1'b0}};
			sgl_q <= {NCH{1'b0}};
			sv_q <= 1'b0;
			main_capture_en <= 1'b0;
		end else begin
			mode_q <= mode_d;
			filt_cnt_q <= filt_cnt_d;
			filt_q <= filt_d;
			filt_prev_q <= filt_q;
			st_q <= st_d;
			seen_false_q <= seen_false_d;
			step_pend_q <= step_pend_d;
			timing_trig <= trig_d;
			step_advance <= step_d;
			seen_true_q <= seen_true_d;
			term_t_q <= term_t_d;
			term_f_q <= term_f_d;
			div_q <= div_d;
			once_q <= once_d;
			gl_q <= gl_d;
			sdat_q <= sdat_d;
			sgl_q <= sgl_d;
			sv_q <= sv_d;
			main_capture_en <= main_trig_cmd & ~acq_start;
		end
	end

	// Registered outputs
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			armed <= 1'b0;
			trig_mode <= MODE_SYNC;
			async_mode <= 1'b0;
			recog_match <= 1'b0;
		end else begin
			armed <= (st_d == ATTA_ARMED);
			trig_mode <= mode_d;
			async_mode <= (mode_d != MODE_SYNC);
			recog_match <= filt_d;
		end
	end
	assign main_term_true  = term_t_q;
	assign main_term_false = term_f_q;
	assign sample_valid    = sv_q;
	assign sample_data     = sdat_q;
	assign sample_glitch   = sgl_q;
endmodule : atta_trigger
`default_nettype wire

// ===== test/atta_trigger_chk.sv
// Assertions for the timing trigger arm block.
// Bound to atta_trigger; reads its ports only.
`default_nettype none
module atta_chk
	import atta_pkg::*;
(
	// Clock and reset
	input wire logic       clk_sys,
	input wire logic       rst,
	// Watched ports
	input wire logic       main_trig_cmd,
	input wire logic       armed,
	input wire logic       timing_trig,
	input wire logic       step_advance,
	input wire logic       main_term_true,
	input wire logic       main_term_false,
	input wire logic       main_capture_en,
	input wire logic       async_mode,
	input wire logic       recog_match,
	input wire logic [1:0] trig_mode
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_sys);
	endclocking
	default disable iff (rst);
	a_fire_needs_arm: assert property (timing_trig |-> $past(armed)) else $error("unarmed");
	a_trig_one_pulse: assert property (timing_trig |=> !timing_trig) else $error("long");
	a_disarm_on_fire: assert property (timing_trig |=> !armed) else $error("still armed");
	a_mode_link: assert property (async_mode == (trig_mode != MODE_SYNC)) else $error("link");
	a_mode_legal: assert property (trig_mode != MODE_RSVD) else $error("bad mode");
	a_capture_cmd: assert property (main_capture_en |-> $past(main_trig_cmd)) else $error("cap");
	a_terms_excl: assert property (!(main_term_true && main_term_false)) else $error("terms");
	a_rise_edge: assert property (timing_trig && trig_mode == MODE_ASYNC_RISE |->
		$past(recog_match)) else $error("rise");
	a_fall_edge: assert property (timing_trig && trig_mode == MODE_ASYNC_FALL |->
		!$past(recog_match)) else $error("fall");
	c_fire: cover property (timing_trig);
	c_step: cover property (step_advance);
	c_false: cover property (main_term_false);
endmodule : atta_chk
bind atta_trigger atta_chk i_chk (.clk_sys, .rst, .main_trig_cmd, .armed, .timing_trig,
	.step_advance, .main_term_true, .main_term_false, .main_capture_en, .async_mode,
	.recog_match, .trig_mode);
`default_nettype wire

// ===== test/atta_sut_model.sv
// Probe and state clock source for the system under test.
// State clock runs only while enabled, low otherwise.
`default_nettype none
module atta_sut_model (
	// Clock and control
	input wire logic       clk_sys,
	input wire logic       clk_en,
	input wire logic [7:0] lvl,
	// Toward the probe
	output logic     [7:0] probe_in,
	output logic           state_clk
);
	timeunit 1ns;
	timeprecision 1ps;
	int n = 0;
	assign probe_in = lvl;
	always @(posedge clk_sys) begin
		n = clk_en ? (n + 1) % 5 : 0;
		state_clk <= clk_en ? state_clk ^ (n == 0) : 1'b0;
	end
endmodule : atta_sut_model
`default_nettype wire

// ===== test/tb.sv
// Self-checking bench for the timing trigger arm block.
// Inputs change by NBA on clk_sys rising edges; probe via the model.
`default_nettype none
module tb
	import atta_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys = 1'b0, rst = 1'b1, acq_start = 1'b0, arm_cmd = 1'b0, clk_en = 1'b0;
	logic uncond_arm_step = 1'b0, main_trig_cmd = 1'b0, trig_mode_we = 1'b0;
	logic main_async_we = 1'b0, main_async_wr = 1'b0, state_clk;
	logic [1:0] trig_mode_wr = 2'h0, trig_mode;
	logic [7:0] lvl = 8'h00, pat_value = 8'h3c, pat_care = 8'hff, probe_in;
	logic [6:0] filter_cycles = 7'h00, sample_div = 7'h03;
	logic [31:0] rnd = 32'h0000_ed81;
	logic armed, timing_trig, step_advance, main_term_true, main_term_false;
	logic main_capture_en, async_mode, sample_valid, recog_match;
	logic [7:0] sample_data, sample_glitch;
	int error_cnt = 0, samples_checked = 0, cycles = 0;
	atta_sut_model i_sut (.clk_sys, .clk_en, .lvl, .probe_in, .state_clk);
	atta_trigger i_dut (.clk_sys, .rst, .probe_in, .state_clk, .acq_start, .arm_cmd,
		.uncond_arm_step, .main_trig_cmd, .pat_value, .pat_care, .filter_cycles,
		.sample_div, .trig_mode_wr, .trig_mode_we, .main_async_wr, .main_async_we, .armed,
		.timing_trig, .step_advance, .main_term_true, .main_term_false, .main_capture_en,
		.trig_mode, .async_mode, .sample_valid, .sample_data, .sample_glitch, .recog_match);
	always #2 clk_sys = ~clk_sys;
	function automatic logic [31:0] lfsr(logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr
	task automatic chk(string n, logic [7:0] e, logic [7:0] g);
		samples_checked++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s exp %h got %h", n, e, g);
		end
	endtask : chk
	task automatic pulse(int w);
		@(posedge clk_sys);
		case (w)
			0: acq_start <= 1'b1;
			1: arm_cmd <= 1'b1;
			2: trig_mode_we <= 1'b1;
			default: main_async_we <= 1'b1;
		endcase
		@(posedge clk_sys);
		{acq_start, arm_cmd, trig_mode_we, main_async_we} <= 4'h0;
	endtask : pulse
	// First cycle of a hit on the trigger or step pulse, 0 if none
	task automatic wait_hit(int n, bit step, output int k);
		k = 0;
		for (int c = 1; c <= n; c++) begin
			@(posedge clk_sys);
			if (k == 0 && (step ? step_advance : timing_trig) === 1'b1) k = c;
		end
	endtask : wait_hit
	// Async sample model: transitions per channel since the last sample
	task automatic async_round();
		logic [7:0] hist[$];
		int         tr;
		int         n;
		logic [7:0] g;
		g = 8'h00;
		n = 3;
		hist.push_back(lvl);
		repeat (3) begin
			rnd = lfsr(rnd);
			lvl <= rnd[7:0];
			hist.push_back(rnd[7:0]);
			@(posedge clk_sys);
		end
		do begin
			@(posedge clk_sys);
			n++;
		end while (sample_valid !== 1'b1);
		for (int b = 0; b < 8; b++) begin
			tr = 0;
			for (int s = 1; s < hist.size(); s++) begin
				tr += int'(hist[s][b] ^ hist[s-1][b]);
			end
			g[b] = (tr > 1);
		end
		chk("sample_period", 8'(sample_div) + 8'h01, 8'(n));
		chk("sample_data", hist[hist.size()-1], sample_data);
		chk("sample_glitch", g, sample_glitch);
	endtask : async_round
	task automatic give_verdict();
		if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			give_verdict();
		end
	end
	initial begin
		int k;
		int j;
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		repeat (4) @(posedge clk_sys);
		chk("reset_mode", 8'h00, {6'h00, trig_mode});
		for (int i = 0; i < 4; i++) begin
			trig_mode_wr <= 2'(i);
			pulse(2);
			repeat (2) @(posedge clk_sys);
			chk("trig_mode", (i == 3) ? 8'h02 : 8'(i), {6'h00, trig_mode});
			chk("async_mode", 8'(i != 0), {7'h00, async_mode});
		end
		for (int i = 0; i < 2; i++) begin
			main_async_wr <= i[0];
			pulse(3);
			repeat (2) @(posedge clk_sys);
			chk("link", 8'(i), {6'h00, trig_mode});
		end
		repeat (16) begin
			rnd = lfsr(rnd);
			lvl <= rnd[7:0];
			pat_care <= rnd[15:8];
			pat_value <= rnd[23:16];
			repeat (8) @(posedge clk_sys);
			chk("recog", 8'(((lvl ^ pat_value) & pat_care) == 8'h00), {7'h00, recog_match});
		end
		pat_value <= 8'h3c;
		pat_care <= 8'hff;
		lvl <= 8'h3c;
		repeat (8) @(posedge clk_sys);
		pulse(1);
		wait_hit(20, 0, k);
		chk("rise_held", 8'h00, 8'(k));
		chk("armed", 8'h01, {7'h00, armed});
		lvl <= 8'h00;
		wait_hit(10, 0, k);
		chk("rise_no_fall", 8'h00, 8'(k));
		lvl <= 8'h3c;
		wait_hit(20, 0, k);
		chk("rise_fire", 8'h01, 8'(k != 0));
		trig_mode_wr <= MODE_ASYNC_FALL;
		pulse(2);
		pulse(0);
		pulse(1);
		wait_hit(20, 0, k);
		chk("fall_held", 8'h00, 8'(k));
		lvl <= 8'h00;
		wait_hit(20, 0, k);
		chk("fall_fire", 8'h01, 8'(k != 0));
		trig_mode_wr <= MODE_ASYNC_RISE;
		filter_cycles <= 7'h14;
		pulse(2);
		pulse(0);
		pulse(1);
		lvl <= 8'h3c;
		wait_hit(10, 0, k);
		lvl <= 8'h00;
		wait_hit(30, 0, j);
		chk("filter_short", 8'h00, 8'(k + j));
		lvl <= 8'h3c;
		wait_hit(60, 0, k);
		chk("filter_hold", 8'h01, 8'(k > 20));
		filter_cycles <= 7'h00;
		lvl <= 8'h00;
		uncond_arm_step <= 1'b1;
		pulse(0);
		clk_en <= 1'b1;
		wait_hit(40, 1, k);
		chk("step", 8'h01, 8'(k != 0));
		chk("step_armed", 8'h01, {7'h00, armed});
		repeat (30) @(posedge clk_sys);
		chk("term_false", 8'h01, {7'h00, main_term_false});
		chk("no_capture", 8'h00, {7'h00, main_capture_en});
		lvl <= 8'h3c;
		main_trig_cmd <= 1'b1;
		repeat (30) @(posedge clk_sys);
		chk("term_true", 8'h01, {7'h00, main_term_true});
		chk("capture", 8'h01, {7'h00, main_capture_en});
		sample_div <= 7'h0f;
		repeat (20) @(posedge clk_sys);
		while (sample_valid !== 1'b1) @(posedge clk_sys);
		repeat (8) async_round();
		give_verdict();
	end
endmodule : tb
`default_nettype wire
